// *** inc/acbd_pkg.sv ***
package acbd_pkg;
    // control byte field positions
    localparam int BIT_START = 7;
    localparam int BIT_POLARITY = 6;
    localparam int BIT_CLK_SEL = 5;
    localparam int BIT_MODE_HI = 4;
    localparam int BIT_MODE_LO = 3;
    localparam int BIT_AUX_HI = 2;
    localparam int BIT_AUX_LO = 0;
    localparam int BYTE_W = 8;
    localparam int AUX_W = 3;
    localparam int RESULT_W = 14;
    localparam int CNT_W = 4;

    // bits counted from the start bit; the last one completes the byte
    localparam logic [CNT_W-1:0] CNT_IDLE = 4'h0;
    localparam logic [CNT_W-1:0] CNT_START = 4'h1;
    localparam logic [CNT_W-1:0] CNT_SEVENTH = 4'h7;

    // mode field codes
    localparam logic [1:0] MODE_SHORT_ACQ = 2'h0;
    localparam logic [1:0] MODE_CALIBRATE = 2'h1;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
    localparam logic [1:0] MODE_LONG_ACQ = 2'h3;

    // external clocks per conversion for each acquisition length
    localparam int CLKS_SHORT_ACQ = 24;
    localparam int CLKS_LONG_ACQ = 32;
    localparam logic [5:0] CLKS_SHORT_W = 6'(CLKS_SHORT_ACQ);
    localparam logic [5:0] CLKS_LONG_W = 6'(CLKS_LONG_ACQ);

    // reset values
    localparam logic [AUX_W-1:0] AUX_RESET = 3'h0;
    localparam logic POLARITY_RESET = 1'b0;
    localparam logic CLK_SEL_RESET = 1'b0;
    localparam logic [1:0] MODE_RESET = MODE_SHORT_ACQ;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 14'h0000;
endpackage : acbd_pkg

// *** sim/acbd_host.sv ***
`timescale 1ns/100ps
module acbd_host (
    output logic sclk,
    output logic cs_n,
    output logic din
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b1;
    end
    // serial clock stands low between frames; bits go out msb first
    task automatic send(input logic [15:0] bits, input int n);
        #7 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            din = bits[i];
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        // released data line shows the inverse so a stale bit never looks valid
        din = ~din;
    endtask : send
endmodule : acbd_host

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import acbd_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic sclk, cs_n, din, conv_done;
    logic [RESULT_W-1:0] result_in, result;
    logic polarity_select, conv_clock_select, mode_bit_hi, mode_bit_lo;
    logic aux_out_2, aux_out_1, aux_out_0, acq_long, power_down;
    logic cal_start, cal_clock_int, conv_begin, result_readable;
    logic [5:0] clks_per_conv;
    logic [7:0] b;
    int failures = 0;
    int check_count = 0;
    int cal_cnt = 0;
    int conv_cnt = 0;
    int c0, v0;

    always #12.5 mclk = ~mclk;

    acbd_host acbd_host_i (.sclk(sclk), .cs_n(cs_n), .din(din));

    acbd_decoder acbd_decoder_i (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .din(din), .result_in(result_in), .conv_done(conv_done),
        .polarity_select(polarity_select), .conv_clock_select(conv_clock_select),
        .mode_bit_hi(mode_bit_hi), .mode_bit_lo(mode_bit_lo), .aux_out_2(aux_out_2),
        .aux_out_1(aux_out_1), .aux_out_0(aux_out_0), .acq_long(acq_long),
        .clks_per_conv(clks_per_conv), .power_down(power_down), .cal_start(cal_start),
        .cal_clock_int(cal_clock_int), .conv_begin(conv_begin), .result(result),
        .result_readable(result_readable));

    // pulses last one cycle, so they are counted rather than sampled late
    always @(posedge mclk) begin
        if (cal_start === 1'b1) cal_cnt++;
        if (conv_begin === 1'b1) conv_cnt++;
    end

    task automatic give_verdict();
        if (failures == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic chk_fields(input logic [7:0] f);
        check("polarity", 14'(polarity_select), 14'(f[6]));
        check("clock", 14'(conv_clock_select), 14'(f[5]));
        check("mode", 14'({mode_bit_hi, mode_bit_lo}), 14'(f[4:3]));
        check("aux", 14'({aux_out_2, aux_out_1, aux_out_0}), 14'(f[2:0]));
        check("acq_long", 14'(acq_long), 14'(f[4:3] == MODE_LONG_ACQ));
        check("clks", 14'(clks_per_conv),
              14'((f[4:3] == MODE_LONG_ACQ) ? CLKS_LONG_ACQ : CLKS_SHORT_ACQ));
        check("power_down", 14'(power_down), 14'(f[4:3] == MODE_POWER_DOWN));
    endtask : chk_fields

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        give_verdict();
    end

    initial begin
        result_in = 14'h0000;
        conv_done = 1'b0;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        tick(2);
        chk_fields(8'h00);
        // every mode code, with a growing run of leading zeros
        for (int m = 0; m < 4; m++) begin
            b = {1'b1, m[0], m[0] ^ m[1], m[1], m[0], 3'h7 ^ 3'(m * 3)};
            c0 = cal_cnt;
            v0 = conv_cnt;
            acbd_host_i.send({8'h00, b}, 8 + m);
            tick(8);
            chk_fields(b);
            check("cal_start", 14'(cal_cnt - c0), 14'(m == 1));
            check("conv_begin", 14'(conv_cnt - v0), 14'(m == 0 || m == 3));
            if (m == 1) check("cal_clock", 14'(cal_clock_int), 14'(b[5]));
        end
        // a byte cut short by deselect leaves every field alone
        acbd_host_i.send(16'h000D, 4);
        tick(8);
        chk_fields(b);
        // internal clock: result held back until the converter finishes
        v0 = conv_cnt;
        acbd_host_i.send(16'h00E2, 8);
        tick(8);
        chk_fields(8'hE2);
        check("conv_begin", 14'(conv_cnt - v0), 14'h0001);
        check("readable", 14'(result_readable), 14'h0000);
        result_in = 14'h2A5C;
        conv_done = 1'b1;
        tick(1);
        conv_done = 1'b0;
        tick(2);
        check("readable", 14'(result_readable), 14'h0001);
        check("result", result, 14'h2A5C);
        // moving to the serial clock calls for a fresh calibration on that clock
        c0 = cal_cnt;
        acbd_host_i.send(16'h0089, 8);
        tick(8);
        chk_fields(8'h89);
        check("cal_start", 14'(cal_cnt - c0), 14'h0001);
        check("cal_clock", 14'(cal_clock_int), 14'h0000);
        // serial clock: result visible while converting
        v0 = conv_cnt;
        acbd_host_i.send(16'h009D, 8);
        tick(8);
        chk_fields(8'h9D);
        check("conv_begin", 14'(conv_cnt - v0), 14'h0001);
        check("readable", 14'(result_readable), 14'h0001);
        result_in = 14'h1234;
        tick(3);
        check("result", result, 14'h1234);
        // a reset in mid-run clears the port outputs and every field
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        chk_fields(8'h00);
        check("readable", 14'(result_readable), 14'h0000);
        give_verdict();
    end
endmodule : tb_top

// *** src/acbd_decoder.sv ***
`timescale 1ns/100ps
module acbd_decoder
    import acbd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic [RESULT_W-1:0] result_in,
    input wire logic conv_done,
    output logic polarity_select,
    output logic conv_clock_select,
    output logic mode_bit_hi,
    output logic mode_bit_lo,
    output logic aux_out_2,
    output logic aux_out_1,
    output logic aux_out_0,
    output logic acq_long,
    output logic [5:0] clks_per_conv,
    output logic power_down,
    output logic cal_start,
    output logic cal_clock_int,
    output logic conv_begin,
    output logic [RESULT_W-1:0] result,
    output logic result_readable
);
    // ---------------- link side, serial clock domain ----------------
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [5:0] shift_q, shift_d;
    logic [BYTE_W-1:0] hold_q = 8'h00;
    logic [BYTE_W-1:0] hold_d;
    logic byte_tgl_q = 1'b0;
    logic byte_tgl_d;
    logic conv_tgl_q = 1'b0;
    logic conv_int_q = 1'b0;

    always_comb begin
        cnt_d = cnt_q;
        shift_d = shift_q;
        hold_d = hold_q;
        byte_tgl_d = byte_tgl_q;
        if (cnt_q == CNT_IDLE) begin
            if (din) begin
                cnt_d = CNT_START;
                shift_d = 6'h00;
            end
        end else if (cnt_q == CNT_SEVENTH) begin
            hold_d = {1'b1, shift_q, din};
            byte_tgl_d = ~byte_tgl_q;
            cnt_d = CNT_IDLE;
        end else begin
            shift_d = {shift_q[4:0], din};
            cnt_d = cnt_q + 4'h1;
        end
    end

    // select high clears framing even while the serial clock stands still
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= CNT_IDLE;
            shift_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
            shift_q <= shift_d;
        end
    end

    // hold and toggle outlive the frame so the other domain can fetch them
    always_ff @(posedge sclk) begin
        if (!cs_n) begin
            hold_q <= hold_d;
            byte_tgl_q <= byte_tgl_d;
        end
    end

    // after seven bits byte bits 6 down to 1 each sit one place lower in the shift register
    always_ff @(negedge sclk) begin
        if (!cs_n && cnt_q == CNT_SEVENTH
                && shift_q[BIT_MODE_HI-1] == shift_q[BIT_MODE_LO-1]) begin
            conv_tgl_q <= ~conv_tgl_q;
            conv_int_q <= shift_q[BIT_CLK_SEL-1];
        end
    end

    // ---------------- control side, mclk domain ----------------
    logic byte_s1_q, byte_s2_q, byte_ack_q;
    logic conv_s1_q, conv_s2_q, conv_ack_q;
    logic new_byte, new_conv;

    always_ff @(posedge mclk) begin
        byte_s1_q <= byte_tgl_q;
        byte_s2_q <= byte_s1_q;
        conv_s1_q <= conv_tgl_q;
        conv_s2_q <= conv_s1_q;
        byte_ack_q <= byte_s2_q;
        conv_ack_q <= conv_s2_q;
    end

    // hold is stable for many mclk periods after its toggle, so it is sampled whole
    assign new_byte = (byte_s2_q != byte_ack_q) && !rst;
    assign new_conv = (conv_s2_q != conv_ack_q) && !rst;

    logic pol_q, pol_d, csel_q, csel_d;
    logic [1:0] mode_q, mode_d;
    logic [AUX_W-1:0] aux_q, aux_d;
    logic cal_q, cal_d, cal_int_q, cal_int_d;
    logic begin_q, begin_d, busy_q, busy_d, rd_q, rd_d, ext_q, ext_d;
    logic [RESULT_W-1:0] res_q, res_d;
    logic acq_q, acq_d, pd_q, pd_d;
    logic [5:0] clks_q, clks_d;

    always_comb begin
        pol_d = pol_q;
        csel_d = csel_q;
        mode_d = mode_q;
        aux_d = aux_q;
        cal_d = 1'b0;
        cal_int_d = cal_int_q;
        begin_d = 1'b0;
        busy_d = busy_q;
        rd_d = rd_q;
        ext_d = ext_q;
        res_d = res_q;
        if (new_byte) begin
            pol_d = hold_q[BIT_POLARITY];
            csel_d = hold_q[BIT_CLK_SEL];
            mode_d = hold_q[BIT_MODE_HI:BIT_MODE_LO];
            aux_d = hold_q[BIT_AUX_HI:BIT_AUX_LO];
            if (hold_q[BIT_MODE_HI:BIT_MODE_LO] == MODE_CALIBRATE) begin
                cal_d = 1'b1;
                cal_int_d = hold_q[BIT_CLK_SEL];
            end
        end
        if (new_conv) begin
            begin_d = 1'b1;
            busy_d = 1'b1;
            ext_d = ~conv_int_q;
            rd_d = ~conv_int_q;
        end else if (busy_q && conv_done) begin
            busy_d = 1'b0;
            rd_d = 1'b1;
            res_d = result_in;
        end else if (busy_q && ext_q) begin
            res_d = result_in; // bits resolve while the serial clock drives the steps
        end
        // decoded one cycle early so these outputs come straight from flops
        acq_d = (mode_d == MODE_LONG_ACQ);
        clks_d = acq_d ? CLKS_LONG_W : CLKS_SHORT_W;
        pd_d = (mode_d == MODE_POWER_DOWN);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pol_q <= POLARITY_RESET;
            csel_q <= CLK_SEL_RESET;
            mode_q <= MODE_RESET;
            aux_q <= AUX_RESET;
            cal_q <= 1'b0;
            cal_int_q <= 1'b0;
            begin_q <= 1'b0;
            busy_q <= 1'b0;
            rd_q <= 1'b0;
            ext_q <= 1'b0;
            res_q <= RESULT_RESET;
            acq_q <= 1'b0;
            clks_q <= CLKS_SHORT_W;
            pd_q <= 1'b0;
        end else begin
            pol_q <= pol_d;
            csel_q <= csel_d;
            mode_q <= mode_d;
            aux_q <= aux_d;
            cal_q <= cal_d;
            cal_int_q <= cal_int_d;
            begin_q <= begin_d;
            busy_q <= busy_d;
            rd_q <= rd_d;
            ext_q <= ext_d;
            res_q <= res_d;
            acq_q <= acq_d;
            clks_q <= clks_d;
            pd_q <= pd_d;
        end
    end

    assign polarity_select = pol_q;
    assign conv_clock_select = csel_q;
    assign mode_bit_hi = mode_q[1];
    assign mode_bit_lo = mode_q[0];
    assign aux_out_2 = aux_q[2];
    assign aux_out_1 = aux_q[1];
    assign aux_out_0 = aux_q[0];
    assign acq_long = acq_q;
    assign clks_per_conv = clks_q;
    assign power_down = pd_q;
    assign cal_start = cal_q;
    assign cal_clock_int = cal_int_q;
    assign conv_begin = begin_q;
    assign result = res_q;
    assign result_readable = rd_q;

    // ---------------- checks ----------------
    // two clock domains here, so every property names its own clock
    aux_reset_a: assert property (@(posedge mclk) rst |=> aux_q == AUX_RESET)
        else $error("port outputs not zero after reset");
    aux_atomic_a: assert property (@(posedge mclk) disable iff (rst)
        aux_q != $past(aux_q) |-> $past(new_byte))
        else $error("port outputs changed without a new byte");
    aux_load_a: assert property (@(posedge mclk) disable iff (rst)
        new_byte |=> aux_q == $past(hold_q[BIT_AUX_HI:BIT_AUX_LO]))
        else $error("port outputs do not follow byte bits 2..0");
    fields_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !new_byte |=> $stable({pol_q, csel_q, mode_q}))
        else $error("fields changed without a complete byte");
    pol_load_a: assert property (@(posedge mclk) disable iff (rst)
        new_byte |=> pol_q == $past(hold_q[BIT_POLARITY]))
        else $error("polarity not taken from bit 6");
    clk_load_a: assert property (@(posedge mclk) disable iff (rst)
        new_byte |=> csel_q == $past(hold_q[BIT_CLK_SEL]))
        else $error("clock select not taken from bit 5");
    mode_load_a: assert property (@(posedge mclk) disable iff (rst)
        new_byte |=> mode_q == $past(hold_q[BIT_MODE_HI:BIT_MODE_LO]))
        else $error("mode not taken from bits 4..3");
    cal_start_a: assert property (@(posedge mclk) disable iff (rst)
        new_byte && hold_q[BIT_MODE_HI:BIT_MODE_LO] == MODE_CALIBRATE
        |=> cal_q && cal_int_q == $past(hold_q[BIT_CLK_SEL]))
        else $error("calibration not started on its clock");
    cal_pulse_a: assert property (@(posedge mclk) disable iff (rst) cal_q |=> !cal_q)
        else $error("calibration start longer than one cycle");
    clks_count_a: assert property (@(posedge mclk) disable iff (rst)
        mode_q == MODE_LONG_ACQ |-> clks_per_conv == 6'h20)
        else $error("long acquisition clock count wrong");
    clks_short_a: assert property (@(posedge mclk) disable iff (rst)
        mode_q != MODE_LONG_ACQ |-> clks_per_conv == 6'h18)
        else $error("short acquisition clock count wrong");
    int_ready_a: assert property (@(posedge mclk) disable iff (rst)
        busy_q && !ext_q |-> !rd_q)
        else $error("internal result readable before done");
    ext_ready_a: assert property (@(posedge mclk) disable iff (rst)
        busy_q && ext_q |-> rd_q)
        else $error("external result not readable during conversion");
    begin_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        begin_q |=> !begin_q)
        else $error("conversion start longer than one cycle");
    start_bit_a: assert property (@(posedge sclk) disable iff (cs_n)
        cnt_q == CNT_IDLE && !din |=> cnt_q == CNT_IDLE)
        else $error("leading zero not ignored");
    byte_msb_a: assert property (@(posedge mclk) disable iff (rst)
        new_byte |-> hold_q[BIT_START])
        else $error("held byte lacks its start bit");

    cal_cov_c: cover property (@(posedge mclk) cal_q);
    conv_ext_c: cover property (@(posedge mclk) (begin_q && ext_q) ##[1:200] (busy_q && rd_q));
    conv_int_c: cover property (@(posedge mclk) (begin_q && !ext_q) ##[1:400] rd_q);
    pd_cov_c: cover property (@(posedge mclk) new_byte ##1 power_down);
endmodule : acbd_decoder
